// ===== cdsr_pkg.sv
package cdsr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned BANK_W = 8;
    localparam int unsigned IRQ_W = 3;
    localparam logic [ADDR_W-1:0] OFS_PRIMARY = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SPECIAL = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_MIRROR = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_BANK_SEL = 4'he;
    localparam logic [BANK_W-1:0] BANK_CABLE = 8'h2f;
    localparam logic [BANK_W-1:0] BANK_EMPTY = 8'h30;
    localparam logic [BANK_W-1:0] BANK_MIRROR = 8'h31;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned P_START = 15;
    localparam int unsigned P_OUT_LO = 13;
    localparam int unsigned P_SHORT = 12;
    localparam int unsigned S_POL = 5;
    localparam int unsigned S_MDI = 4;
    localparam int unsigned S_FORCE = 3;
    localparam int unsigned S_PWR = 2;
    localparam int unsigned S_LOOP = 1;
    localparam int unsigned M_SHORT = 15;
    localparam int unsigned M_START = 12;
    localparam int unsigned M_FORCE = 11;
    localparam int unsigned M_PWR = 10;
    localparam int unsigned M_LOOP = 9;
    localparam int unsigned IRQ_DONE = 0;
    localparam int unsigned IRQ_POL = 1;
    localparam int unsigned IRQ_MDI = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [BANK_W-1:0] BANK_RST = 8'h00;
    localparam logic FORCE_RST = 1'b0;
    localparam logic PWR_RST = 1'b1;
    localparam logic LOOP_RST = 1'b0;
    localparam logic [8:0] COUNT_RST = 9'h000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    typedef enum logic [1:0] {
        OUT_NORMAL = 2'b00,
        OUT_OPEN = 2'b01,
        OUT_SHORT = 2'b10,
        OUT_FAILED = 2'b11
    } cdsr_outcome_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LAUNCH = 2'b01,
        ST_RUN = 2'b10
    } cdsr_state_t;

    typedef struct packed {
        logic short_near;
        cdsr_outcome_t outcome;
        logic [8:0] count;
    } cdsr_result_t;
endpackage

// ===== cdsr_regs.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module cdsr_regs (
    input wire logic MCLK_IN, // 100 MHz clock
    input wire logic RST_IN, // Async reset, active high
    input wire logic [cdsr_pkg::ADDR_W-1:0] ADDR_IN, // Register offset
    input wire logic [cdsr_pkg::DATA_W-1:0] WDATA_IN, // Write data
    input wire logic WR_IN, // Write strobe
    input wire logic RD_IN, // Read strobe
    output logic [cdsr_pkg::DATA_W-1:0] RDATA_OUT, // Read data, cycle after strobe
    output logic IRQ_OUT, // Level interrupt
    output logic TEST_START_OUT, // One-cycle launch to measurement engine
    input wire logic TEST_DONE_IN, // One-cycle completion from engine
    input wire cdsr_pkg::cdsr_result_t TEST_RESULT_IN, // Result beside done
    input wire logic POL_REV_IN, // Receive polarity reversed, async
    input wire logic MDI_MODE_IN, // 1 = MDI, 0 = MDI-X, async
    output logic FORCE_LINK_OUT, // Treat link as passing
    output logic PWR_SAVE_DIS_OUT, // Power saving disabled
    output logic REMOTE_LOOP_OUT // Cable receive pair to transmit pair
);
    import cdsr_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [BANK_W-1:0] bank_v,
                                 input logic [BANK_W-1:0] want_bank,
                                 input logic [ADDR_W-1:0] addr_v,
                                 input logic [ADDR_W-1:0] want_addr);
        hit = (bank_v == want_bank) && (addr_v == want_addr);
    endfunction

    logic [BANK_W-1:0] bank_reg;
    cdsr_state_t state_reg;
    cdsr_result_t result_reg;
    logic force_reg;
    logic pwr_reg;
    logic loop_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic irq_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic pol_s1_reg;
    logic pol_s2_reg;
    logic pol_d_reg;
    logic mdi_s1_reg;
    logic mdi_s2_reg;
    logic mdi_d_reg;
    logic sel_prim;
    logic sel_spec;
    logic sel_mirr;
    logic sel_stat;
    logic sel_mask;
    logic sel_bank;
    logic ctrl_wr;
    logic start_req;
    logic start_bit;
    logic [DATA_W-1:0] prim_word;
    logic [DATA_W-1:0] spec_word;
    logic [DATA_W-1:0] mirr_word;

    assign sel_prim = hit(bank_reg, BANK_CABLE, ADDR_IN, OFS_PRIMARY);
    assign sel_spec = hit(bank_reg, BANK_CABLE, ADDR_IN, OFS_SPECIAL);
    assign sel_stat = hit(bank_reg, BANK_CABLE, ADDR_IN, OFS_IRQ_STAT);
    assign sel_mask = hit(bank_reg, BANK_CABLE, ADDR_IN, OFS_IRQ_MASK);
    assign sel_mirr = hit(bank_reg, BANK_MIRROR, ADDR_IN, OFS_MIRROR);
    // Bank select answers in every bank; other middle-bank offsets are dead
    assign sel_bank = (ADDR_IN == OFS_BANK_SEL);

    // ------------------------------------------------------------
    // Bank select
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            bank_reg <= BANK_RST;
        end else if (WR_IN && sel_bank) begin
            bank_reg <= WDATA_IN[BANK_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Cable test sequencer
    // ------------------------------------------------------------
    // A zero written to the start bit never aborts a run in flight
    assign start_req = (WR_IN && sel_prim && WDATA_IN[P_START])
                     || (WR_IN && sel_mirr && WDATA_IN[M_START]);
    assign start_bit = (state_reg != ST_IDLE);
    assign TEST_START_OUT = (state_reg == ST_LAUNCH);

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_req) begin
                        state_reg <= ST_LAUNCH;
                    end
                end
                ST_LAUNCH: begin
                    state_reg <= ST_RUN;
                end
                ST_RUN: begin
                    if (TEST_DONE_IN) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Results change only when a run ends, so they are stable once start reads zero
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            result_reg <= '{short_near: 1'b0, outcome: OUT_NORMAL, count: COUNT_RST};
        end else if (state_reg == ST_RUN && TEST_DONE_IN) begin
            result_reg <= TEST_RESULT_IN;
        end
    end

    // ------------------------------------------------------------
    // Line controls, shared by both aliases
    // ------------------------------------------------------------
    assign ctrl_wr = WR_IN && (sel_spec || sel_mirr);

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            force_reg <= FORCE_RST;
            pwr_reg <= PWR_RST;
            loop_reg <= LOOP_RST;
        end else if (ctrl_wr) begin
            force_reg <= sel_spec ? WDATA_IN[S_FORCE] : WDATA_IN[M_FORCE];
            pwr_reg <= sel_spec ? WDATA_IN[S_PWR] : WDATA_IN[M_PWR];
            loop_reg <= sel_spec ? WDATA_IN[S_LOOP] : WDATA_IN[M_LOOP];
        end
    end

    assign FORCE_LINK_OUT = force_reg;
    assign PWR_SAVE_DIS_OUT = pwr_reg;
    assign REMOTE_LOOP_OUT = loop_reg;

    // ------------------------------------------------------------
    // Line status synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pol_s1_reg <= 1'b0;
            pol_s2_reg <= 1'b0;
            pol_d_reg <= 1'b0;
            mdi_s1_reg <= 1'b0;
            mdi_s2_reg <= 1'b0;
            mdi_d_reg <= 1'b0;
        end else begin
            pol_s1_reg <= POL_REV_IN;
            pol_s2_reg <= pol_s1_reg;
            pol_d_reg <= pol_s2_reg;
            mdi_s1_reg <= MDI_MODE_IN;
            mdi_s2_reg <= mdi_s1_reg;
            mdi_d_reg <= mdi_s2_reg;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Set wins over a same-cycle write-one clear so no event is lost
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (WR_IN && sel_stat) begin
            irq_stat_next = irq_stat_reg & ~WDATA_IN[IRQ_W-1:0];
        end
        if (state_reg == ST_RUN && TEST_DONE_IN) begin
            irq_stat_next[IRQ_DONE] = 1'b1;
        end
        if (pol_s2_reg != pol_d_reg) begin
            irq_stat_next[IRQ_POL] = 1'b1;
        end
        if (mdi_s2_reg != mdi_d_reg) begin
            irq_stat_next[IRQ_MDI] = 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_stat_reg <= IRQ_RST;
            irq_mask_reg <= IRQ_RST;
            irq_reg <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (WR_IN && sel_mask) begin
                irq_mask_reg <= WDATA_IN[IRQ_W-1:0];
            end
            irq_reg <= |(irq_stat_next & (WR_IN && sel_mask ? WDATA_IN[IRQ_W-1:0]
                                                             : irq_mask_reg));
        end
    end

    assign IRQ_OUT = irq_reg;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        prim_word = '0;
        prim_word[P_START] = start_bit;
        prim_word[P_OUT_LO+1:P_OUT_LO] = result_reg.outcome;
        prim_word[P_SHORT] = result_reg.short_near;
        prim_word[8:0] = result_reg.count;
        spec_word = '0;
        spec_word[S_POL] = pol_s2_reg;
        spec_word[S_MDI] = mdi_s2_reg;
        spec_word[S_FORCE] = force_reg;
        spec_word[S_PWR] = pwr_reg;
        spec_word[S_LOOP] = loop_reg;
        mirr_word = '0;
        mirr_word[M_SHORT] = result_reg.short_near;
        mirr_word[P_OUT_LO+1:P_OUT_LO] = result_reg.outcome;
        mirr_word[M_START] = start_bit;
        mirr_word[M_FORCE] = force_reg;
        mirr_word[M_PWR] = pwr_reg;
        mirr_word[M_LOOP] = loop_reg;
        mirr_word[8:0] = result_reg.count;
    end

    // Data stands only in the cycle after the strobe; unmapped reads return zero
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rdata_reg <= '0;
        end else if (!RD_IN) begin
            rdata_reg <= '0;
        end else if (sel_bank) begin
            rdata_reg <= {{(DATA_W-BANK_W){1'b0}}, bank_reg};
        end else if (sel_prim) begin
            rdata_reg <= prim_word;
        end else if (sel_spec) begin
            rdata_reg <= spec_word;
        end else if (sel_mirr) begin
            rdata_reg <= mirr_word;
        end else if (sel_stat) begin
            rdata_reg <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg};
        end else if (sel_mask) begin
            rdata_reg <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_reg};
        end else begin
            rdata_reg <= '0;
        end
    end

    assign RDATA_OUT = rdata_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    a_start_launch: assert property (
        (state_reg == ST_IDLE && start_req) |=> TEST_START_OUT ##1 !TEST_START_OUT)
        else $error("start request did not give one launch pulse");
    a_start_selfclear: assert property (
        (state_reg == ST_RUN && TEST_DONE_IN) |=> !start_bit)
        else $error("start bit did not self-clear after done");
    a_results_stable: assert property (
        !(state_reg == ST_RUN && TEST_DONE_IN) |=> $stable(result_reg))
        else $error("results changed outside run completion");
    a_outcome_read: assert property (
        (RD_IN && sel_prim && !sel_bank) |=> RDATA_OUT[14:13] == $past(result_reg.outcome))
        else $error("outcome field read wrong");
    a_short_read: assert property (
        (RD_IN && sel_prim && !sel_bank) |=> RDATA_OUT[12] == $past(result_reg.short_near))
        else $error("near short flag read wrong");
    a_count_read: assert property (
        (RD_IN && sel_mirr && !sel_bank) |=> RDATA_OUT[8:0] == $past(result_reg.count))
        else $error("fault count read wrong");
    a_line_status: assert property (
        (RD_IN && sel_spec) |=> RDATA_OUT[5:4] == {$past(pol_s2_reg), $past(mdi_s2_reg)})
        else $error("line status bits read wrong");
    a_force_write: assert property (
        (WR_IN && sel_spec) |=> FORCE_LINK_OUT == $past(WDATA_IN[3]))
        else $error("force link not written");
    a_pwr_mirror: assert property (
        (WR_IN && sel_mirr) |=> PWR_SAVE_DIS_OUT == $past(WDATA_IN[10]))
        else $error("power saving not written through mirror");
    a_loop_alias: assert property (
        (WR_IN && sel_mirr) |=> REMOTE_LOOP_OUT == $past(WDATA_IN[9]))
        else $error("loopback alias mismatch");
    a_empty_bank: assert property (
        (RD_IN && bank_reg == BANK_EMPTY && !sel_bank) |=> RDATA_OUT == 16'h0000)
        else $error("reserved bank read nonzero");
    a_zero_ignored: assert property (
        (state_reg == ST_RUN && !TEST_DONE_IN) |=> state_reg == ST_RUN)
        else $error("run aborted without done");
    a_busy_no_relaunch: assert property (
        (state_reg != ST_IDLE && start_req) |=> !TEST_START_OUT)
        else $error("start accepted while a run was busy");
    a_prim_count: assert property (
        (RD_IN && sel_prim) |=> RDATA_OUT[8:0] == $past(result_reg.count))
        else $error("primary fault count read wrong");
    a_prim_start: assert property (
        (RD_IN && sel_prim) |=> RDATA_OUT[15] == $past(start_bit))
        else $error("primary start bit read wrong");
    a_prim_reserved: assert property (
        (RD_IN && sel_prim) |=> RDATA_OUT[11:9] == 3'h0)
        else $error("primary reserved bits nonzero");
    a_spec_reserved: assert property (
        (RD_IN && sel_spec) |=> RDATA_OUT[15:6] == 10'h000 && !RDATA_OUT[0])
        else $error("special reserved bits nonzero");
    a_spec_ctrl: assert property (
        (RD_IN && sel_spec) |=> RDATA_OUT[3:1] == $past({force_reg, pwr_reg, loop_reg}))
        else $error("special control bits read wrong");
    a_mirror_start: assert property (
        (RD_IN && sel_mirr) |=> RDATA_OUT[12] == $past(start_bit))
        else $error("mirror start bit read wrong");
    a_mirror_result: assert property (
        (RD_IN && sel_mirr) |=>
            RDATA_OUT[15:13] == $past({result_reg.short_near, result_reg.outcome}))
        else $error("mirror short flag or outcome read wrong");
    a_mirror_ctrl: assert property (
        (RD_IN && sel_mirr) |=> RDATA_OUT[11:9] == $past({force_reg, pwr_reg, loop_reg}))
        else $error("mirror control bits read wrong");
    a_loop_write: assert property (
        (WR_IN && sel_spec) |=> REMOTE_LOOP_OUT == $past(WDATA_IN[1]))
        else $error("loopback not written");
    a_pwr_write: assert property (
        (WR_IN && sel_spec) |=> PWR_SAVE_DIS_OUT == $past(WDATA_IN[2]))
        else $error("power saving not written");
    a_force_mirror: assert property (
        (WR_IN && sel_mirr) |=> FORCE_LINK_OUT == $past(WDATA_IN[11]))
        else $error("force link not written through mirror");
    a_empty_write: assert property (
        (WR_IN && bank_reg == BANK_EMPTY && !sel_bank) |=> $stable({force_reg, pwr_reg, loop_reg}))
        else $error("reserved bank write changed controls");
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import cdsr_pkg::*;
    logic mclk, rst, wr, rd, done, pol, mdi;
    logic irq, tstart, force_o, pwr_o, loop_o;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [15:0] prev;
    cdsr_result_t res;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;

    cdsr_regs dut (
        .MCLK_IN(mclk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq), .TEST_START_OUT(tstart),
        .TEST_DONE_IN(done), .TEST_RESULT_IN(res), .POL_REV_IN(pol), .MDI_MODE_IN(mdi),
        .FORCE_LINK_OUT(force_o), .PWR_SAVE_DIS_OUT(pwr_o), .REMOTE_LOOP_OUT(loop_o)
    );

    // ------------------------------------------------------------
    // Clock, run limit and report
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // A full run takes well under 1000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            $display("[FAIL] run length expected below 3000 seen %0d", cyc);
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] exp, input string n);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(n, exp, rdata);
    endtask

    task automatic sel(input logic [BANK_W-1:0] b);
        wr_reg(OFS_BANK_SEL, {8'h00, b});
    endtask

    task automatic settle_irq(input logic exp);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq line", {15'h0000, exp}, {15'h0000, irq});
    endtask

    // One diagnostic run; controls are force 0, power-save disable 1, loopback 0
    task automatic run_test(input logic mir, input logic [1:0] o, input logic s,
                            input logic [8:0] c);
        int n;
        n = 0;
        if (mir) begin
            sel(BANK_MIRROR);
            wr_reg(OFS_MIRROR, 16'h1400);
        end else begin
            wr_reg(OFS_PRIMARY, 16'h8000);
        end
        for (int i = 0; i < 4; i++) begin
            #1;
            if (tstart === 1'b1) n++;
            @(posedge mclk);
        end
        chk("launch pulse count", 16'h0001, n[15:0]);
        if (mir) sel(BANK_CABLE);
        wr_reg(OFS_PRIMARY, 16'h0000);
        wr_reg(OFS_PRIMARY, 16'h8000);
        #1;
        chk("no relaunch while busy", 16'h0000, {15'h0000, tstart});
        rd_chk(OFS_PRIMARY, prev | 16'h8000, "start bit while running");
        @(posedge mclk);
        done <= 1'b1;
        res <= '{short_near: s, outcome: cdsr_outcome_t'(o), count: c};
        @(posedge mclk);
        done <= 1'b0;
        prev = {1'b0, o, s, 3'b000, c};
        rd_chk(OFS_PRIMARY, prev, "result word");
        rd_chk(OFS_IRQ_STAT, 16'h0001, "done status");
        chk("irq after run", 16'h0001, {15'h0000, irq});
        wr_reg(OFS_IRQ_STAT, 16'h0001);
        settle_irq(1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        done = 1'b0;
        pol = 1'b0;
        mdi = 1'b0;
        addr = '0;
        wdata = '0;
        res = '0;
        prev = 16'h0000;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk("controls after reset", 16'h0002, {13'h0, force_o, pwr_o, loop_o});
        rd_chk(OFS_BANK_SEL, 16'h0000, "bank select reset");
        @(posedge mclk);
        #1;
        chk("read data after its cycle", 16'h0000, rdata);
        sel(BANK_CABLE);
        rd_chk(OFS_SPECIAL, 16'h0004, "special reset");
        rd_chk(OFS_PRIMARY, 16'h0000, "primary reset");
        rd_chk(OFS_BANK_SEL, 16'h002f, "bank select");
        $display("test reset values done");

        wr_reg(OFS_SPECIAL, 16'hfff9);
        rd_chk(OFS_SPECIAL, 16'h0008, "special after write");
        chk("control pins", 16'h0004, {13'h0, force_o, pwr_o, loop_o});
        wr_reg(OFS_SPECIAL, 16'h0002);
        rd_chk(OFS_SPECIAL, 16'h0002, "loopback set");
        chk("control pins loop", 16'h0001, {13'h0, force_o, pwr_o, loop_o});
        wr_reg(4'h8, 16'hffff);
        rd_chk(4'h8, 16'h0000, "unmapped offset");
        $display("test control fields done");

        sel(BANK_MIRROR);
        rd_chk(OFS_MIRROR, 16'h0200, "mirror view");
        wr_reg(OFS_MIRROR, 16'he9ff);
        rd_chk(OFS_MIRROR, 16'h0800, "mirror after write");
        sel(BANK_EMPTY);
        rd_chk(OFS_BANK_SEL, 16'h0030, "empty bank select");
        rd_chk(4'h0, 16'h0000, "empty bank offset");
        wr_reg(4'h2, 16'h0004);
        sel(BANK_CABLE);
        rd_chk(OFS_SPECIAL, 16'h0008, "special via mirror");
        wr_reg(OFS_SPECIAL, 16'h0004);
        $display("test bank aliasing done");

        @(posedge mclk);
        pol <= 1'b1;
        mdi <= 1'b1;
        repeat (6) @(posedge mclk);
        rd_chk(OFS_SPECIAL, 16'h0034, "line status");
        chk("irq masked", 16'h0000, {15'h0000, irq});
        rd_chk(OFS_IRQ_STAT, 16'h0006, "line change status");
        wr_reg(OFS_IRQ_MASK, 16'h0006);
        settle_irq(1'b1);
        wr_reg(OFS_IRQ_STAT, 16'h0002);
        rd_chk(OFS_IRQ_STAT, 16'h0004, "partial clear");
        settle_irq(1'b1);
        wr_reg(OFS_IRQ_STAT, 16'h0004);
        settle_irq(1'b0);
        wr_reg(OFS_IRQ_MASK, 16'h0001);
        rd_chk(OFS_IRQ_MASK, 16'h0001, "mask readback");
        $display("test line status and interrupt done");

        run_test(1'b0, 2'b00, 1'b0, 9'h1ff);
        run_test(1'b0, 2'b01, 1'b1, 9'h000);
        run_test(1'b0, 2'b10, 1'b1, 9'h0a5);
        run_test(1'b1, 2'b11, 1'b0, 9'h100);
        sel(BANK_MIRROR);
        rd_chk(OFS_MIRROR, 16'h6500, "mirror results");
        $display("test cable diagnostic done");
        tally_and_finish();
    end
endmodule
